// File: src/wexio_map.svh
`ifndef WEXIO_MAP_SVH
`define WEXIO_MAP_SVH
// Acceptance time choices in microseconds.
`define WEXIO_ACC_T0_US       100
`define WEXIO_ACC_T1_US       1000
`define WEXIO_ACC_T2_US       4000
`define WEXIO_ACC_T3_US       8000
`define WEXIO_ACC_T4_US       16000
`define WEXIO_ACC_DEFAULT     3'h4
`define WEXIO_PULSE_MS        40
`define WEXIO_CHARGE_MAX_S    60
`define WEXIO_CLK_MHZ         250
`define WEXIO_BEAMS           6
`define WEXIO_TSU             5
`define WEXIO_SCHED_BITS      5
`endif

// File: src/wexio_pkg.sv
package wexio_pkg;
  typedef enum logic [3:0] {
    WEXIO_IDLE  = 4'h1,
    WEXIO_ACC   = 4'h2,
    WEXIO_FIRE  = 4'h4,
    WEXIO_PULSE = 4'h8
  } wexio_state_t;
endpackage : wexio_pkg

// File: src/wexio_filter.sv
`timescale 1ns/1ps
`include "wexio_map.svh"
// Stability filter: the output follows the input only after the input held
// one value for the selected number of cycles.
module wexio_filter #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  input  wire logic [31:0]  hold_cycles,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] last;
    logic [31:0]  cnt;
    logic [W-1:0] out;
  } wexio_flt_t;
  wexio_flt_t s_reg;
  wexio_flt_t s_next;

  always_comb begin
    s_next = s_reg;
    if (din != s_reg.last) begin
      s_next.last = din;
      s_next.cnt  = 32'h0;
    end else if (s_reg.cnt + 32'h1 >= hold_cycles) begin
      s_next.out = din;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.out;

  chk_filter_needs_stable: assert property (@(posedge mclk) disable iff (rst)
    $changed(s_reg.out) |-> $past(din) == s_reg.out) else $error("filter output moved unheld");
endmodule : wexio_filter

// File: src/wexio_top.sv
`timescale 1ns/1ps
`include "wexio_map.svh"
// Contact inputs are active high meaning closed; contact outputs high meaning closed.
module wexio_top #(
  parameter int PULSE_CYC = `WEXIO_PULSE_MS * 1000 * `WEXIO_CLK_MHZ,
  parameter int ACC_T0    = `WEXIO_ACC_T0_US * `WEXIO_CLK_MHZ,
  parameter int ACC_T1    = `WEXIO_ACC_T1_US * `WEXIO_CLK_MHZ,
  parameter int ACC_T2    = `WEXIO_ACC_T2_US * `WEXIO_CLK_MHZ,
  parameter int ACC_T3    = `WEXIO_ACC_T3_US * `WEXIO_CLK_MHZ,
  parameter int ACC_T4    = `WEXIO_ACC_T4_US * `WEXIO_CLK_MHZ
) (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           keyswitch_on,
  input  wire logic                           ctrl_switch_in,
  input  wire logic                           hv_in,
  input  wire logic [`WEXIO_BEAMS-1:0]        beam_sel_in,
  input  wire logic [`WEXIO_TSU-1:0]          tsu_in,
  input  wire logic                           res_shutter_in,
  input  wire logic [`WEXIO_SCHED_BITS-1:0]   sched_in,
  input  wire logic                           start_in,
  input  wire logic                           guide_in,
  input  wire logic                           estop_loop_in,
  input  wire logic                           interlock_loop_in,
  input  wire logic [2:0]                     sched_acc_sel,
  input  wire logic [2:0]                     start_acc_sel,
  input  wire logic                           cap_charged,
  input  wire logic                           res_shutter_open_fb,
  input  wire logic [`WEXIO_BEAMS-1:0]        branch_open_fb,
  input  wire logic [`WEXIO_TSU-1:0]          tsu_active_fb,
  input  wire logic                           shot_done,
  input  wire logic                           energy_ok,
  output logic                                ext_acceptable_out,
  output logic                                ready_out,
  output logic                                hv_on_out,
  output logic                                end_out,
  output logic                                mon_normal_out,
  output logic                                mon_trouble_out,
  output logic                                estop_out,
  output logic                                res_shutter_stat_out,
  output logic [`WEXIO_BEAMS-1:0]             branch_stat_out,
  output logic [`WEXIO_TSU-1:0]               tsu_stat_out,
  output logic                                hv_charge_cmd,
  output logic                                res_shutter_cmd,
  output logic                                flashlamp_cmd,
  output logic [`WEXIO_BEAMS-1:0]             branch_open_cmd,
  output logic [`WEXIO_BEAMS-1:0]             shutter_lamp_out,
  output logic [`WEXIO_TSU-1:0]               tsu_cmd,
  output logic                                guide_cmd,
  output logic                                fire_out,
  output logic [`WEXIO_SCHED_BITS-1:0]        sched_latched
);
  localparam int NIN = 1 + 1 + `WEXIO_BEAMS + `WEXIO_TSU + 1 + 1 + 1 + 1 + 1 + 1;

  function automatic logic [31:0] acc_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    acc_cycles = 32'(ACC_T0);
      3'h1:    acc_cycles = 32'(ACC_T1);
      3'h2:    acc_cycles = 32'(ACC_T2);
      3'h3:    acc_cycles = 32'(ACC_T3);
      default: acc_cycles = 32'(ACC_T4);
    endcase
  endfunction : acc_cycles

  // Pin synchronisers; stage one feeds stage two only.
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  assign pin_raw = {keyswitch_on, ctrl_switch_in, beam_sel_in, tsu_in, hv_in,
                    res_shutter_in, start_in, guide_in, estop_loop_in,
                    interlock_loop_in};
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic                          key_s;
  logic                          ctrl_s;
  logic [`WEXIO_BEAMS-1:0]       beam_s;
  logic [`WEXIO_TSU-1:0]         tsu_s;
  logic                          hv_s;
  logic                          res_s;
  logic                          start_s;
  logic                          guide_s;
  logic                          estop_loop_s;
  logic                          ilk_s;
  assign {key_s, ctrl_s, beam_s, tsu_s, hv_s, res_s, start_s, guide_s, estop_loop_s,
          ilk_s} = sync2_reg;

  // Schedule code is sampled as a word so a half-changed code never latches.
  logic [`WEXIO_SCHED_BITS-1:0] sch1_reg;
  logic [`WEXIO_SCHED_BITS-1:0] sch2_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sch1_reg <= '0;
      sch2_reg <= '0;
    end else begin
      sch1_reg <= sched_in;
      sch2_reg <= sch1_reg;
    end
  end

  logic [`WEXIO_SCHED_BITS-1:0] sched_filt;
  logic                         start_filt;
  wexio_filter #(.W(`WEXIO_SCHED_BITS)) u_sched_flt (
    .mclk        (mclk),
    .rst         (rst),
    .din         (sch2_reg),
    .hold_cycles (acc_cycles(sched_acc_sel)),
    .dout        (sched_filt)
  );
  wexio_filter #(.W(1)) u_start_flt (
    .mclk        (mclk),
    .rst         (rst),
    .din         (start_s),
    .hold_cycles (acc_cycles(start_acc_sel)),
    .dout        (start_filt)
  );

  typedef struct packed {
    wexio_pkg::wexio_state_t         st;
    logic [31:0]                     cnt;
    logic                            mon_ok;
    logic [`WEXIO_SCHED_BITS-1:0]    sched;
    logic                            start_prev;
  } wexio_top_t;
  wexio_top_t s_reg;
  wexio_top_t s_next;

  logic stopped;
  logic ext_ok;
  logic lase_ok;
  assign stopped = !estop_loop_s || !key_s;
  assign ext_ok  = ctrl_s && !stopped;
  assign lase_ok = ext_ok && ilk_s && hv_s && cap_charged;

  always_comb begin
    s_next = s_reg;
    s_next.start_prev = start_filt;
    if (ext_ok) begin
      s_next.sched = sched_filt;
    end
    case (s_reg.st)
      wexio_pkg::WEXIO_IDLE: begin
        // Only a fresh accepted edge fires, so a held start gives one shot.
        if (start_filt && !s_reg.start_prev && lase_ok && res_s) begin
          s_next.st = wexio_pkg::WEXIO_FIRE;
        end
      end
      wexio_pkg::WEXIO_FIRE: begin
        if (shot_done) begin
          s_next.st     = wexio_pkg::WEXIO_PULSE;
          s_next.cnt    = 32'(PULSE_CYC);
          s_next.mon_ok = energy_ok;
        end else if (!lase_ok) begin
          s_next.st = wexio_pkg::WEXIO_IDLE;
        end
      end
      wexio_pkg::WEXIO_PULSE: begin
        if (s_reg.cnt <= 32'h1) begin
          s_next.st  = wexio_pkg::WEXIO_IDLE;
          s_next.cnt = 32'h0;
        end else begin
          s_next.cnt = s_reg.cnt - 32'h1;
        end
      end
      default: s_next.st = wexio_pkg::WEXIO_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg    <= '0;
      s_reg.st <= wexio_pkg::WEXIO_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs: commands are honoured only in external control; estop_out and the status outputs always follow their inputs.
  assign ext_acceptable_out   = ext_ok;
  assign hv_charge_cmd        = ext_ok && hv_s;
  assign hv_on_out            = hv_charge_cmd;
  assign ready_out            = hv_charge_cmd && cap_charged;
  assign branch_open_cmd      = (ext_ok && ilk_s) ? beam_s : '0;
  assign shutter_lamp_out     = branch_open_cmd;
  assign res_shutter_cmd      = ext_ok && ilk_s && res_s;
  assign flashlamp_cmd        = res_shutter_cmd;
  assign guide_cmd            = ext_ok && ilk_s && guide_s;
  assign tsu_cmd              = (ext_ok && ilk_s) ? tsu_s : '0;
  // Gated by the permit so a stop or an open interlock cuts the beam in the same cycle,
  // not one cycle later when the state machine has fallen back to idle.
  assign fire_out             = (s_reg.st == wexio_pkg::WEXIO_FIRE) && lase_ok;
  assign end_out              = s_reg.st == wexio_pkg::WEXIO_PULSE;
  assign mon_normal_out       = end_out && s_reg.mon_ok;
  assign mon_trouble_out      = end_out && !s_reg.mon_ok;
  assign estop_out            = estop_loop_s;
  assign res_shutter_stat_out = res_shutter_open_fb;
  assign branch_stat_out      = branch_open_fb;
  assign tsu_stat_out         = tsu_active_fb;
  assign sched_latched        = s_reg.sched;

  chk_estop_blocks_all: assert property (@(posedge mclk) disable iff (rst)
    !estop_loop_s |-> !ext_acceptable_out && !res_shutter_cmd && !fire_out)
    else $error("stop loop open but laser active");
  chk_ilk_closes_shut: assert property (@(posedge mclk) disable iff (rst)
    !ilk_s |-> branch_open_cmd == '0 && !res_shutter_cmd && !guide_cmd && !fire_out)
    else $error("interlock open but shutters driven");
  chk_ready_needs_hv: assert property (@(posedge mclk) disable iff (rst)
    ready_out |-> hv_s && cap_charged && ext_ok) else $error("ready without charge");
  chk_end_pulse_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(end_out) |-> s_reg.cnt == 32'(PULSE_CYC)) else $error("end pulse length wrong");
  chk_mon_exclusive: assert property (@(posedge mclk) disable iff (rst)
    $rose(end_out) |-> mon_normal_out != mon_trouble_out) else $error("monitor pulse wrong");
  chk_fire_needs_start: assert property (@(posedge mclk) disable iff (rst)
    $rose(fire_out) |-> $past(start_filt)) else $error("fired without accepted start");
  chk_beam_follow: assert property (@(posedge mclk) disable iff (rst)
    ext_ok && ilk_s |-> shutter_lamp_out == beam_s) else $error("beam not followed");
  chk_ignore_inputs: assert property (@(posedge mclk) disable iff (rst)
    !ext_acceptable_out |-> !hv_charge_cmd && tsu_cmd == '0) else $error("input honoured");
endmodule : wexio_top

// File: tb/wexio_plant.sv
`timescale 1ns/1ps
`include "wexio_map.svh"
// Shutters, timesharing units, charger and lamp behind the external control block.
module wexio_plant (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     hv_charge_cmd,
  input  wire logic                     res_shutter_cmd,
  input  wire logic [`WEXIO_BEAMS-1:0]  branch_open_cmd,
  input  wire logic [`WEXIO_TSU-1:0]    tsu_cmd,
  input  wire logic                     fire_out,
  input  wire logic                     energy_good,
  output logic                          cap_charged,
  output logic                          res_shutter_open_fb,
  output logic [`WEXIO_BEAMS-1:0]       branch_open_fb,
  output logic [`WEXIO_TSU-1:0]         tsu_active_fb,
  output logic                          shot_done,
  output logic                          energy_ok
);
  logic [3:0] chg_cnt;
  logic [1:0] shot_cnt;
  // Mechanics lag their commands by a cycle, so status cannot be a copy of the command.
  always_ff @(posedge mclk) begin
    res_shutter_open_fb <= res_shutter_cmd & ~rst;
    branch_open_fb      <= rst ? '0 : branch_open_cmd;
    tsu_active_fb       <= rst ? '0 : tsu_cmd;
    chg_cnt             <= (rst | ~hv_charge_cmd) ? 4'h0 : chg_cnt + {3'h0, chg_cnt != 4'hf};
    shot_cnt            <= (rst | ~fire_out) ? 2'h0 : shot_cnt + {1'h0, shot_cnt != 2'h3};
    shot_done           <= ~rst & fire_out & (shot_cnt == 2'h2);
    // Energy result is only valid beside shot_done; otherwise it shows the wrong answer.
    energy_ok           <= (fire_out & (shot_cnt == 2'h2)) ? energy_good : ~energy_good;
  end
  assign cap_charged = hv_charge_cmd & (chg_cnt == 4'hf);
endmodule : wexio_plant

// File: tb/tb_wexio_top.sv
`timescale 1ns/1ps
`include "wexio_map.svh"
module tb_wexio_top;
  logic mclk = 1'b0, rst = 1'b1, keyswitch_on = 1'b0, ctrl_switch_in = 1'b0, hv_in = 1'b0;
  logic res_shutter_in = 1'b0, start_in = 1'b0, guide_in = 1'b0, energy_good = 1'b1;
  logic estop_loop_in = 1'b0, interlock_loop_in = 1'b0;
  logic [`WEXIO_BEAMS-1:0] beam_sel_in = '0, branch_open_fb, branch_stat_out;
  logic [`WEXIO_BEAMS-1:0] branch_open_cmd, shutter_lamp_out;
  logic [`WEXIO_TSU-1:0] tsu_in = '0, tsu_active_fb, tsu_stat_out, tsu_cmd;
  logic [`WEXIO_SCHED_BITS-1:0] sched_in = '0, sched_latched;
  logic [2:0] sched_acc_sel = 3'h4, start_acc_sel = 3'h4;
  logic cap_charged, res_shutter_open_fb, shot_done, energy_ok, ext_acceptable_out;
  logic ready_out, hv_on_out, end_out, mon_normal_out, mon_trouble_out, estop_out;
  logic res_shutter_stat_out, hv_charge_cmd, res_shutter_cmd, flashlamp_cmd, guide_cmd;
  logic fire_out;
  int fail_count = 0, n_checks = 0, k;

  wexio_top #(.PULSE_CYC(20), .ACC_T0(3), .ACC_T1(5), .ACC_T2(7), .ACC_T3(9), .ACC_T4(11))
    dut (.*);
  wexio_plant plant (.*);

  always #2 mclk = ~mclk;

  task complete_run;
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task bound(input logic ok);
    if (ok !== 1'b1) begin
      fail_count++;
      complete_run;
    end
  endtask : bound

  task t_control;
    beam_sel_in = 6'h03;
    cyc(6);
    chk(branch_open_cmd, 32'h0);
    chk(ext_acceptable_out, 32'h0);
    ctrl_switch_in = 1'b1;
    cyc(4);
    chk(ext_acceptable_out, 32'h1);
    chk({shutter_lamp_out, branch_open_cmd}, 32'h0c3);
    chk(branch_stat_out, 32'h03);
    tsu_in = 5'h11;
    res_shutter_in = 1'b1;
    guide_in = 1'b1;
    cyc(5);
    chk(tsu_stat_out, 32'h11);
    chk({res_shutter_cmd, flashlamp_cmd, res_shutter_stat_out, guide_cmd}, 32'hf);
    chk(estop_out, 32'h1);
  endtask : t_control

  task t_charge;
    hv_in = 1'b1;
    cyc(4);
    chk({hv_charge_cmd, hv_on_out, ready_out}, 32'h6);
    for (k = 0; k < 40 && ready_out !== 1'b1; k++) cyc(1);
    bound(ready_out);
  endtask : t_charge

  task t_sched;
    // A code held shorter than the acceptance window must not be taken.
    sched_in = 5'h01;
    cyc(7);
    sched_in = 5'h02;
    cyc(1);
    chk(sched_latched, 32'h0);
    cyc(20);
    chk(sched_latched, 32'h02);
  endtask : t_sched

  task t_shot(input logic good, input int hold);
    energy_good = good;
    cyc(5);
    start_in = 1'b1;
    for (k = 0; k < 40 && fire_out !== 1'b1; k++) cyc(1);
    bound(fire_out);
    chk(k >= hold + 1 && k <= hold + 7, 32'h1);
    chk(branch_open_cmd, 32'h03);
    for (k = 0; k < 10 && end_out !== 1'b1; k++) cyc(1);
    bound(end_out);
    chk({mon_normal_out, mon_trouble_out}, {30'h0, good, ~good});
    for (k = 0; k < 40 && end_out === 1'b1; k++) cyc(1);
    chk(k, 32'd20);
    cyc(20);
    // Start still held: a new rising edge is needed for another shot.
    chk(fire_out, 32'h0);
    start_in = 1'b0;
    // The start filter must see the release, or the next shot finds no fresh edge.
    cyc(20);
  endtask : t_shot

  task t_accsel;
    for (int s = 0; s < 4; s++) begin
      sched_acc_sel = 3'(s);
      sched_in = 5'h08 + 5'(s);
      for (k = 0; k < 40 && sched_latched !== sched_in; k++) cyc(1);
      chk(k >= 2 * s + 5 && k <= 2 * s + 8, 32'h1);
    end
    start_acc_sel = 3'h0;
  endtask : t_accsel

  task t_interlock;
    interlock_loop_in = 1'b0;
    cyc(4);
    chk({res_shutter_cmd, branch_open_cmd, guide_cmd, fire_out}, 32'h0);
    interlock_loop_in = 1'b1;
    cyc(4);
  endtask : t_interlock

  task t_estop;
    hv_in = 1'b0;
    cyc(4);
    chk({hv_on_out, ready_out}, 32'h0);
    keyswitch_on = 1'b0;
    cyc(4);
    chk(ext_acceptable_out, 32'h0);
    keyswitch_on = 1'b1;
    cyc(4);
    chk(ext_acceptable_out, 32'h1);
    estop_loop_in = 1'b0;
    cyc(4);
    chk(estop_out, 32'h0);
    chk({ext_acceptable_out, hv_charge_cmd, ready_out, res_shutter_cmd}, 32'h0);
  endtask : t_estop

  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    keyswitch_on = 1'b1;
    estop_loop_in = 1'b1;
    interlock_loop_in = 1'b1;
    t_control;
    t_charge;
    t_sched;
    t_shot(1'b1, 11);
    t_shot(1'b0, 11);
    t_accsel;
    t_shot(1'b1, 3);
    t_interlock;
    t_estop;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run;
  end
endmodule : tb_wexio_top
